// ---- inc/isp_hex_regs.vh ----
`ifndef ISP_HEX_REGS_VH
`define ISP_HEX_REGS_VH
// Character framing
`define HEX_DATA_BITS 4'h8
// Start-of-frame character ':'
`define HEX_START_CHAR 8'h3A
// Data program record type
`define HEX_TYPE_DATA 8'h00
// Sync character from host for baud measurement ('U')
`define HEX_SYNC_CHAR 8'h55
// Shortest accepted bit period, in clock cycles
`define HEX_MIN_BIT 16'h0008
// Bit period used until the first measurement
`define HEX_DEF_BIT 16'h015B
// FIFO depth and width
`define HEX_FIFO_DEPTH 8
`define HEX_FIFO_WIDTH 8
`endif

// ---- src/hex_fifo.v ----
`timescale 1ns/1ps
`include "isp_hex_regs.vh"
module hex_fifo #(
    parameter WIDTH = `HEX_FIFO_WIDTH,
    parameter DEPTH = `HEX_FIFO_DEPTH,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk)
    begin
        if (push)
            mem[wr_r] <= in_data;
    end
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : rd_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // hex_fifo

// ---- src/isp_hex_record_receiver.v ----
// Functional notes
// - 8N1 characters, no flow control
// - Measure host baud rate automatically
// - Colon starts every frame
// - Length byte counts data bytes
// - Load offset used for data records only
// - Record type selects command interpretation
// - Zero or more data bytes accepted
// - Hex digit pairs become bytes
// - Frame accepted when byte sum zero
`timescale 1ns/1ps
`include "isp_hex_regs.vh"
module isp_hex_record_receiver #(
    parameter FIFO_DEPTH = `HEX_FIFO_DEPTH
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Serial line from host
    input wire rxd,
    // Baud status
    output reg baud_locked,
    output reg [15:0] bit_period,
    // Frame header, valid from the type byte until next colon
    output reg frame_start,
    output reg [7:0] rec_type,
    output reg [7:0] rec_len,
    output reg [15:0] load_addr,
    output reg load_addr_valid,
    // Data bytes, held back in the FIFO
    output reg data_valid,
    input wire data_ready,
    output reg [7:0] data_byte,
    output reg [15:0] data_addr,
    // Frame verdict pulses
    output reg frame_ok,
    output reg frame_err,
    output reg overflow
);
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_BITS = 2'h2;
    localparam RX_STOP = 2'h3;
    localparam F_HUNT = 3'h0;
    localparam F_LEN = 3'h1;
    localparam F_ADDR = 3'h2;
    localparam F_TYPE = 3'h3;
    localparam F_DATA = 3'h4;
    localparam F_SUM = 3'h5;

    reg rx_m_r;
    reg rx_s_r;
    reg rx_d_r;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            rx_d_r <= 1'b1;
        end
        else
        begin
            rx_m_r <= rxd;
            rx_s_r <= rx_m_r;
            rx_d_r <= rx_s_r;
        end
    end
    wire fall = rx_d_r && !rx_s_r;

    // Autobaud: host first sends 'U'; the start bit low time is one bit.
    // Only the start bit is timed, so a noisy first edge gives a bad rate
    // that is kept until reset, since the lock is never released.
    reg [15:0] meas_r;
    reg measuring_r;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meas_r <= 16'h0000;
            measuring_r <= 1'b0;
            baud_locked <= 1'b0;
            bit_period <= `HEX_DEF_BIT;
        end
        else if (!baud_locked)
        begin
            if (!measuring_r && fall)
            begin
                measuring_r <= 1'b1;
                meas_r <= 16'h0001;
            end
            else if (measuring_r && !rx_s_r)
                meas_r <= (meas_r == 16'hFFFF) ? meas_r : meas_r + 16'h0001;
            else if (measuring_r)
            begin
                measuring_r <= 1'b0;
                if (meas_r >= `HEX_MIN_BIT)
                begin
                    bit_period <= meas_r;
                    baud_locked <= 1'b1;
                end
            end
        end
    end

    // UART receiver, 8 data bits, 1 stop bit, no parity
    reg [1:0] rx_st_r;
    reg [15:0] tick_r;
    reg [3:0] nbit_r;
    reg [7:0] sh_r;
    reg ch_v_r;
    reg [7:0] ch_r;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_st_r <= RX_IDLE;
            tick_r <= 16'h0000;
            nbit_r <= 4'h0;
            sh_r <= 8'h00;
            ch_v_r <= 1'b0;
            ch_r <= 8'h00;
        end
        else
        begin
            ch_v_r <= 1'b0;
            case (rx_st_r)
                RX_IDLE:
                    if (fall && baud_locked)
                    begin
                        rx_st_r <= RX_START;
                        tick_r <= {1'b0, bit_period[15:1]};
                    end
                RX_START:
                    if (tick_r == 16'h0000)
                    begin
                        tick_r <= bit_period - 16'h0001;
                        nbit_r <= 4'h0;
                        rx_st_r <= rx_s_r ? RX_IDLE : RX_BITS;
                    end
                    else
                        tick_r <= tick_r - 16'h0001;
                RX_BITS:
                    if (tick_r == 16'h0000)
                    begin
                        tick_r <= bit_period - 16'h0001;
                        sh_r <= {rx_s_r, sh_r[7:1]};
                        nbit_r <= nbit_r + 4'h1;
                        if (nbit_r == `HEX_DATA_BITS - 4'h1)
                            rx_st_r <= RX_STOP;
                    end
                    else
                        tick_r <= tick_r - 16'h0001;
                RX_STOP:
                    if (tick_r == 16'h0000)
                    begin
                        rx_st_r <= RX_IDLE;
                        // Framing error drops the character
                        ch_v_r <= rx_s_r;
                        ch_r <= sh_r;
                    end
                    else
                        tick_r <= tick_r - 16'h0001;
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // ASCII hex digit decode
    reg [3:0] nib;
    reg is_hex;
    always @*
    begin
        is_hex = 1'b1;
        nib = 4'h0;
        if (ch_r >= 8'h30 && ch_r <= 8'h39)
            nib = ch_r[3:0];
        else if ((ch_r >= 8'h41 && ch_r <= 8'h46) ||
                 (ch_r >= 8'h61 && ch_r <= 8'h66))
            nib = ch_r[3:0] + 4'h9;
        else
            is_hex = 1'b0;
    end

    // Frame parser
    reg [2:0] f_st_r;
    reg half_r;
    reg [3:0] hi_r;
    reg [7:0] sum_r;
    reg [7:0] left_r;
    reg ab_r;
    reg [15:0] addr_r;
    wire fifo_in_ready;
    wire byte_done = ch_v_r && is_hex && half_r;
    wire [7:0] byte_v = {hi_r, nib};
    wire [7:0] sum_n = sum_r + byte_v;
    reg push_r;
    reg [7:0] push_d_r;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            f_st_r <= F_HUNT;
            half_r <= 1'b0;
            hi_r <= 4'h0;
            sum_r <= 8'h00;
            left_r <= 8'h00;
            ab_r <= 1'b0;
            addr_r <= 16'h0000;
            push_r <= 1'b0;
            push_d_r <= 8'h00;
            frame_start <= 1'b0;
            rec_type <= 8'h00;
            rec_len <= 8'h00;
            load_addr <= 16'h0000;
            load_addr_valid <= 1'b0;
            frame_ok <= 1'b0;
            frame_err <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            frame_start <= 1'b0;
            frame_ok <= 1'b0;
            frame_err <= 1'b0;
            // Judged at the push itself, so a pop in between is no loss
            overflow <= push_r && !fifo_in_ready;
            push_r <= 1'b0;
            if (ch_v_r && ch_r == `HEX_START_CHAR)
            begin
                // A colon always restarts, even mid-frame
                f_st_r <= F_LEN;
                half_r <= 1'b0;
                sum_r <= 8'h00;
                ab_r <= 1'b0;
                frame_start <= 1'b1;
                load_addr_valid <= 1'b0;
                if (f_st_r != F_HUNT)
                    frame_err <= 1'b1;
            end
            else if (ch_v_r && f_st_r != F_HUNT && !is_hex)
            begin
                f_st_r <= F_HUNT;
                frame_err <= 1'b1;
            end
            else if (ch_v_r && f_st_r != F_HUNT)
            begin
                half_r <= !half_r;
                hi_r <= nib;
            end
            if (byte_done && f_st_r != F_HUNT)
            begin
                sum_r <= sum_n;
                case (f_st_r)
                    F_LEN:
                    begin
                        rec_len <= byte_v;
                        left_r <= byte_v;
                        f_st_r <= F_ADDR;
                    end
                    F_ADDR:
                    begin
                        addr_r <= {addr_r[7:0], byte_v};
                        ab_r <= 1'b1;
                        if (ab_r)
                            f_st_r <= F_TYPE;
                    end
                    F_TYPE:
                    begin
                        rec_type <= byte_v;
                        load_addr <= addr_r;
                        load_addr_valid <= (byte_v == `HEX_TYPE_DATA);
                        f_st_r <= (left_r == 8'h00) ? F_SUM : F_DATA;
                    end
                    F_DATA:
                    begin
                        push_r <= 1'b1;
                        push_d_r <= byte_v;
                        left_r <= left_r - 8'h01;
                        if (left_r == 8'h01)
                            f_st_r <= F_SUM;
                    end
                    F_SUM:
                    begin
                        f_st_r <= F_HUNT;
                        frame_ok <= (sum_n == 8'h00);
                        frame_err <= (sum_n != 8'h00);
                    end
                    default:
                        f_st_r <= F_HUNT;
                endcase
            end
        end
    end

    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_pop = fifo_out_valid && (!data_valid || data_ready);
    hex_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(push_d_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Output register stage; address advances per delivered data byte
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            data_valid <= 1'b0;
            data_byte <= 8'h00;
            data_addr <= 16'h0000;
        end
        else
        begin
            if (frame_start)
                data_addr <= 16'h0000;
            else if (load_addr_valid && f_st_r == F_DATA && !data_valid &&
                     !fifo_out_valid && data_addr == 16'h0000)
                data_addr <= load_addr;
            else if (data_valid && data_ready)
                data_addr <= data_addr + 16'h0001;
            if (fifo_pop)
            begin
                data_valid <= 1'b1;
                data_byte <= fifo_out_data;
            end
            else if (data_ready)
                data_valid <= 1'b0;
        end
    end
endmodule // isp_hex_record_receiver

// ---- verification/isp_hex_record_receiver_monitor.sv ----
`timescale 1ns/1ps
module hex_rx_monitor (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Link status and header
    input wire baud_locked,
    input wire [15:0] bit_period,
    input wire frame_start,
    input wire [7:0] rec_type,
    input wire load_addr_valid,
    // Data stream
    input wire data_valid,
    input wire data_ready,
    input wire [7:0] data_byte,
    // Verdicts
    input wire frame_ok,
    input wire frame_err,
    input wire overflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    start_pulse_a: assert property (frame_start |=> !frame_start)
        else $error("frame start not a pulse");
    start_locked_a: assert property (frame_start |-> baud_locked)
        else $error("frame decoded before lock");
    lock_sticky_a: assert property (baud_locked |=> baud_locked)
        else $error("baud lock dropped");
    period_hold_a: assert property (baud_locked && $past(baud_locked)
        |=> $stable(bit_period) && bit_period >= 16'h0008)
        else $error("bit period moved or too short");
    verdict_one_a: assert property (frame_ok |-> !frame_err ##1 !frame_ok)
        else $error("frame verdict malformed");
    err_pulse_a: assert property (frame_err |=> !frame_err)
        else $error("error not a pulse");
    addr_type_a: assert property (load_addr_valid |-> rec_type == 8'h00)
        else $error("offset valid for other type");
    addr_clear_a: assert property (frame_start |-> ##2 !load_addr_valid)
        else $error("offset valid kept past start");
    data_hold_a: assert property (data_valid && !data_ready
        |=> data_valid && $stable(data_byte))
        else $error("data byte dropped while stalled");
    cover property (frame_ok);
    cover property (frame_err);
    cover property (overflow ##1 data_valid && !data_ready);
endmodule // hex_rx_monitor

bind isp_hex_record_receiver hex_rx_monitor mon (.clk(clk), .rst(rst),
    .baud_locked(baud_locked), .bit_period(bit_period),
    .frame_start(frame_start), .rec_type(rec_type),
    .load_addr_valid(load_addr_valid), .data_valid(data_valid),
    .data_ready(data_ready), .data_byte(data_byte), .frame_ok(frame_ok),
    .frame_err(frame_err), .overflow(overflow));

// ---- verification/hex_host.sv ----
`timescale 1ns/1ps
module hex_host #(
    parameter BIT = 16
) (
    // Clock
    input wire clk,
    // Serial line to device, idles high
    output logic rxd
);
    // Lower-case letter digits while set
    logic lc = 1'h0;
    initial rxd = 1'h1;
    task send_char(input logic [7:0] c);
        logic [9:0] f;
        begin
            f = {1'h1, c, 1'h0};
            for (int i = 0; i < 10; i++)
            begin
                rxd <= f[i];
                repeat (BIT) @(posedge clk);
            end
        end
    endtask
    function logic [7:0] hexc(input logic [3:0] n);
        hexc = (n < 4'hA) ? {4'h3, n} : (lc ? 8'h57 : 8'h37) + {4'h0, n};
    endfunction
    task send_byte(input logic [7:0] b);
        begin
            send_char(hexc(b[7:4]));
            send_char(hexc(b[3:0]));
        end
    endtask
    // A non-zero flip corrupts the checksum on purpose
    task send_frame(input logic [7:0] len, input logic [15:0] adr,
        input logic [7:0] typ, input logic [7:0] seed,
        input logic [7:0] flip);
        logic [7:0] sum;
        begin
            send_char(8'h3A);
            send_byte(len);
            send_byte(adr[15:8]);
            send_byte(adr[7:0]);
            send_byte(typ);
            sum = len + adr[15:8] + adr[7:0] + typ;
            for (int i = 0; i < len; i++)
            begin
                send_byte(8'(seed + i));
                sum = sum + 8'(seed + i);
            end
            send_byte((8'h00 - sum) ^ flip);
        end
    endtask
endmodule // hex_host

// ---- verification/tb_isp_hex_record_receiver.sv ----
`timescale 1ns/1ps
module tb_isp_hex_record_receiver;
    localparam BIT = 16;
    logic clk = 1'h0;
    logic rst;
    logic data_ready;
    wire rxd, baud_locked, frame_start, load_addr_valid, data_valid;
    wire frame_ok, frame_err, overflow;
    wire [15:0] bit_period, load_addr, data_addr;
    wire [7:0] rec_type, rec_len, data_byte;
    int miscompares = 0, comparisons = 0, cycles = 0;
    int n_start = 0, n_ok = 0, n_err = 0, n_ov = 0;
    logic [7:0] rx_q[$];
    logic [15:0] ad_q[$];

    isp_hex_record_receiver dut (.clk(clk), .rst(rst), .rxd(rxd),
        .baud_locked(baud_locked), .bit_period(bit_period),
        .frame_start(frame_start), .rec_type(rec_type), .rec_len(rec_len),
        .load_addr(load_addr), .load_addr_valid(load_addr_valid),
        .data_valid(data_valid), .data_ready(data_ready),
        .data_byte(data_byte), .data_addr(data_addr), .frame_ok(frame_ok),
        .frame_err(frame_err), .overflow(overflow));
    hex_host #(.BIT(BIT)) host (.clk(clk), .rxd(rxd));

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (frame_start === 1'h1) n_start <= n_start + 1;
        if (frame_ok === 1'h1) n_ok <= n_ok + 1;
        if (frame_err === 1'h1) n_err <= n_err + 1;
        if (overflow === 1'h1) n_ov <= n_ov + 1;
        if (data_valid === 1'h1 && data_ready === 1'h1)
        begin
            rx_q.push_back(data_byte);
            ad_q.push_back(data_addr);
        end
        if (cycles == 40000)
        begin
            miscompares++;
            $display("MISMATCH timeout expected done seen %0d cycles", cycles);
            wrap_up();
        end
    end

    task chk(input logic [31:0] exp, input logic [31:0] got, input string s);
        begin
            comparisons++;
            if (got !== exp)
            begin
                miscompares++;
                $display("MISMATCH %s expected %0h seen %0h", s, exp, got);
            end
        end
    endtask
    // Verdicts and data land before the last stop bit ends
    task settle;
        repeat (4) @(posedge clk);
    endtask
    task run_frame(input logic [7:0] len, input logic [15:0] adr,
        input logic [7:0] typ, input logic [7:0] seed,
        input logic [7:0] flip);
        int s, o, e;
        begin
            s = n_start;
            o = n_ok;
            e = n_err;
            rx_q.delete();
            ad_q.delete();
            host.send_frame(len, adr, typ, seed, flip);
            settle();
            chk(s + 1, n_start, "starts");
            chk(len, rec_len, "rec_len");
            chk(typ, rec_type, "rec_type");
            chk(typ == 8'h00, load_addr_valid, "addr_valid");
            if (typ == 8'h00)
                chk(adr, load_addr, "load_addr");
            chk(o + (flip == 8'h00), n_ok, "frame_ok");
            chk(e + (flip != 8'h00), n_err, "frame_err");
            chk(len, rx_q.size(), "count");
            for (int i = 0; i < len; i++)
                chk(8'(seed + i), rx_q[i], "data");
            if (typ == 8'h00)
                for (int i = 0; i < len; i++)
                    chk(16'(adr + i), ad_q[i], "data_addr");
        end
    endtask
    task t_sync;
        begin
            chk(16'h015B, bit_period, "default_period");
            chk(0, baud_locked, "early_lock");
            host.send_char(8'h55);
            settle();
            chk(1, baud_locked, "locked");
            chk(BIT, bit_period, "bit_period");
            // The tail of the sync character still runs through the receiver
            repeat (12 * BIT) @(posedge clk);
        end
    endtask
    task t_frames;
        begin
            run_frame(8'h03, 16'hA5C3, 8'h00, 8'hFE, 8'h00);
            run_frame(8'h00, 16'h0000, 8'h01, 8'h00, 8'h00);
            host.lc = 1'h1;
            run_frame(8'h02, 16'h7F01, 8'h04, 8'h30, 8'h00);
            host.lc = 1'h0;
            run_frame(8'h01, 16'h1234, 8'h00, 8'h5A, 8'h01);
            run_frame(8'h02, 16'h1234, 8'h00, 8'h5A, 8'h00);
        end
    endtask
    task t_bad_char;
        int e;
        begin
            e = n_err;
            host.send_char(8'h3A);
            host.send_byte(8'h01);
            host.send_char(8'h3A);
            settle();
            chk(e + 1, n_err, "restart");
            host.send_char(8'h47);
            settle();
            chk(e + 2, n_err, "bad_char");
            host.send_char(8'h5A);
            host.send_char(8'h31);
            settle();
            chk(e + 2, n_err, "outside");
            run_frame(8'h01, 16'h0010, 8'h00, 8'h3C, 8'h00);
        end
    endtask
    task t_stall;
        int v;
        begin
            v = n_ov;
            rx_q.delete();
            ad_q.delete();
            data_ready <= 1'h0;
            host.send_frame(8'h0C, 16'h0200, 8'h00, 8'h80, 8'h00);
            settle();
            // Output stage plus eight FIFO words hold 9 of the 12 bytes
            chk(3, n_ov - v, "overflow");
            data_ready <= 1'h1;
            for (int k = 0; k < 40 && data_valid !== 1'h0; k++)
                @(posedge clk);
            chk(0, data_valid, "drained");
            chk(9, rx_q.size(), "kept");
            for (int i = 0; i < 9; i++)
                chk(8'(8'h80 + i), rx_q[i], "kept_data");
            for (int i = 0; i < 9; i++)
                chk(16'(16'h0200 + i), ad_q[i], "kept_addr");
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d miscompares %0d", comparisons,
                miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial
    begin
        rst = 1'h1;
        data_ready = 1'h1;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        t_sync();
        t_frames();
        t_bad_char();
        t_stall();
        wrap_up();
    end
endmodule // tb_isp_hex_record_receiver
